// *** verilog/lcsc_pkg.sv ***
`default_nettype none
package lcsc_pkg;
  localparam int unsigned CLK_HZ          = 20000000;
  localparam int unsigned MENU_TIMEOUT_S  = 30;
  localparam int unsigned MENU_TIMEOUT_CYC = MENU_TIMEOUT_S * CLK_HZ;
  localparam int unsigned TEST_HOLD_MS    = 3000;
  localparam int unsigned TEST_HOLD_CYC   = TEST_HOLD_MS * (CLK_HZ / 1000);
  localparam int unsigned STEP_MS         = 10;
  localparam int unsigned STEP_CYC        = STEP_MS * (CLK_HZ / 1000);
  localparam int unsigned NUM_BEAMS       = 16;
  localparam int unsigned BEAM_IDX_W      = 5;
  localparam int unsigned MENU_VIEW_W     = 4;
  localparam logic [3:0]  VIEW_RESET      = 4'h0;
  localparam logic [3:0]  VIEW_LANGUAGE   = 4'hA;
  localparam logic [3:0]  VIEW_SETUP      = 4'hD;
  localparam logic [3:0]  VIEW_LAST       = 4'hD;

  // multipurpose pin function codes
  typedef enum logic [1:0] {
    LCSC_PIN_SWITCH,
    LCSC_PIN_ERROR,
    LCSC_PIN_SETUP,
    LCSC_PIN_TEACH
  } lcsc_pin_e;

  // switching output policy while sync is lost
  typedef enum logic [1:0] {
    LCSC_NOSYNC_HOLD,
    LCSC_NOSYNC_OFF,
    LCSC_NOSYNC_ON
  } lcsc_nosync_e;

  typedef enum logic [1:0] {
    LCSC_TOL_NONE,
    LCSC_TOL_MINUS,
    LCSC_TOL_PLUS,
    LCSC_TOL_BOTH
  } lcsc_tol_e;

  typedef struct packed {
    logic up;
    logic down;
    logic back;
    logic run;
    logic enter;
    logic teach;
  } lcsc_keys_s;

  typedef struct packed {
    lcsc_pin_e    pin_func;
    lcsc_nosync_e nosync;
    lcsc_tol_e    tol;
    logic [4:0]   taught_count;
  } lcsc_cfg_s;

  localparam lcsc_cfg_s CFG_DEFAULT = '{pin_func: LCSC_PIN_SWITCH, nosync: LCSC_NOSYNC_HOLD,
                                        tol: LCSC_TOL_NONE, taught_count: 5'h00};
endpackage : lcsc_pkg
`default_nettype wire

// *** verilog/lcsc_tick_timer.sv ***
`timescale 1ns/1ps
`default_nettype none
// counts cycles while run is high; restart reloads, done is a level once reached
module lcsc_tick_timer #(
  parameter int unsigned LIMIT = 4
) (
  input  wire logic clk,
  input  wire logic reset,
  input  wire logic run,
  input  wire logic restart,
  output logic      done
);
  localparam int unsigned W = $clog2(LIMIT + 1);
  logic [W-1:0] count_reg;
  logic [W-1:0] count_next;

  assign done       = (count_reg == W'(LIMIT));
  assign count_next = (restart || !run) ? '0 : (done ? count_reg : count_reg + W'(1));

  always_ff @(posedge clk) begin
    if (reset) begin
      count_reg <= '0;
    end else begin
      count_reg <= count_next;
    end
  end
endmodule : lcsc_tick_timer
`default_nettype wire

// *** verilog/lcsc_beam_eval.sv ***
`timescale 1ns/1ps
`default_nettype none
// beam counting, sync supervision and tolerant count match
module lcsc_beam_eval #(
  parameter int unsigned BEAMS = lcsc_pkg::NUM_BEAMS
) (
  input  wire logic [BEAMS-1:0]              beam_blocked,
  input  wire lcsc_pkg::lcsc_tol_e           tol,
  input  wire logic [lcsc_pkg::BEAM_IDX_W-1:0] taught_count,
  output logic                               sync_lost,
  output logic                               count_match,
  output logic [lcsc_pkg::BEAM_IDX_W-1:0]    blocked_count
);
  function automatic logic [lcsc_pkg::BEAM_IDX_W-1:0] popcount(input logic [BEAMS-1:0] v);
    logic [lcsc_pkg::BEAM_IDX_W-1:0] n;
    n = '0;
    for (int i = 0; i < BEAMS; i++) begin
      n = n + lcsc_pkg::BEAM_IDX_W'(v[i]);
    end
    return n;
  endfunction : popcount

  // bit 0 is beam 1, nearest the display
  assign blocked_count = popcount(beam_blocked);
  // top and bottom beams carry sync; one free beam keeps it
  assign sync_lost = beam_blocked[0] && beam_blocked[BEAMS-1];

  wire exact_hit = (blocked_count == taught_count);
  wire minus_hit = (blocked_count + lcsc_pkg::BEAM_IDX_W'(1) == taught_count);
  wire plus_hit  = (blocked_count == taught_count + lcsc_pkg::BEAM_IDX_W'(1));

  assign count_match = exact_hit ||
                       ((tol == lcsc_pkg::LCSC_TOL_MINUS || tol == lcsc_pkg::LCSC_TOL_BOTH)
                        && minus_hit) ||
                       ((tol == lcsc_pkg::LCSC_TOL_PLUS || tol == lcsc_pkg::LCSC_TOL_BOTH)
                        && plus_hit);
endmodule : lcsc_beam_eval
`default_nettype wire

// *** verilog/lcsc_control.sv ***
// Behaviour
// - in display mode any key opens the configuration menu
// - thirty seconds without adjustment in the menu returns to display mode
// - reopening the menu resumes at the last used view
// - edited settings take effect only when the menu is left
// - keys navigate up, down, back, run; enter confirms a selection
// - language must be chosen at first start and after default reset
// - setup starts by teach key on setup entry or by setup-configured pin
// - show progress; success shows message and all beams free; failure no message
// - beams numbered consecutively, beam 1 nearest the display
// - sync uses top and bottom beams, kept while either is free
// - both sync beams blocked raises error output and error message
// - a sync-loss policy sets switching outputs while sync is lost
// - test input open or low means normal operation
// - test input high three seconds then released steps beams off in turn
// - tolerance -1, +1 or both widens the taught count match
// - multipurpose pin is switch output, error output, setup or teach input
`timescale 1ns/1ps
`default_nettype none
module lcsc_control #(
  parameter int unsigned BEAMS       = lcsc_pkg::NUM_BEAMS,
  parameter int unsigned MENU_CYC    = lcsc_pkg::MENU_TIMEOUT_CYC,
  parameter int unsigned TEST_CYC    = lcsc_pkg::TEST_HOLD_CYC,
  parameter int unsigned STEP_CYCLES = lcsc_pkg::STEP_CYC
) (
  input  wire logic                 clk,
  input  wire logic                 reset,
  input  wire lcsc_pkg::lcsc_keys_s keys,
  input  wire logic                 setting_adjust,
  input  wire lcsc_pkg::lcsc_cfg_s  edit_cfg,
  input  wire logic                 factory_reset,
  input  wire logic [BEAMS-1:0]     beam_blocked,
  input  wire logic                 test_input,
  input  wire logic                 multipurpose_io_pin_in,
  input  wire logic                 setup_ok,
  input  wire logic                 setup_fail,
  output logic                      menu_active,
  output logic [lcsc_pkg::MENU_VIEW_W-1:0] menu_view,
  output lcsc_pkg::lcsc_cfg_s       active_cfg,
  output logic                      language_required,
  output logic                      setup_running,
  output logic                      setup_success_msg,
  output logic                      show_all_free,
  output logic                      error_msg,
  output logic                      error_output,
  output logic                      primary_switch_output,
  output logic                      multipurpose_io_pin_out,
  output logic                      multipurpose_io_pin_oe_n,
  output logic                      teach_request,
  output logic [BEAMS-1:0]          emitter_beam_off
);
  typedef enum {LCSC_DISPLAY, LCSC_MENU} lcsc_mode_e;
  typedef enum {LCSC_T_IDLE, LCSC_T_HOLD, LCSC_T_STEP} lcsc_test_e;

  // pin inputs pass two flops; stage one feeds nothing else
  logic [1:0] test_sync_reg;
  logic [1:0] pin_sync_reg;
  logic [1:0] pin_hist_reg;
  always_ff @(posedge clk) begin
    if (reset) begin
      test_sync_reg <= 2'h0;
      pin_sync_reg  <= 2'h0;
      pin_hist_reg  <= 2'h0;
    end else begin
      test_sync_reg <= {test_sync_reg[0], test_input};
      pin_sync_reg  <= {pin_sync_reg[0], multipurpose_io_pin_in};
      pin_hist_reg  <= {pin_hist_reg[0], pin_sync_reg[1]};
    end
  end
  wire test_high = test_sync_reg[1];
  wire pin_rise  = pin_hist_reg[0] && !pin_hist_reg[1];

  // keys are same-domain one-cycle pulses
  wire any_key = |keys;

  lcsc_mode_e mode_reg;
  lcsc_mode_e mode_next;
  logic [lcsc_pkg::MENU_VIEW_W-1:0] view_reg;
  logic [lcsc_pkg::MENU_VIEW_W-1:0] view_next;
  lcsc_pkg::lcsc_cfg_s cfg_reg;
  logic lang_req_reg;
  logic menu_timeout;

  lcsc_tick_timer #(.LIMIT(MENU_CYC)) u_menu_timer (
    .clk     (clk),
    .reset   (reset),
    .run     (mode_reg == LCSC_MENU),
    .restart (any_key || setting_adjust),
    .done    (menu_timeout)
  );

  wire in_menu     = (mode_reg == LCSC_MENU);
  wire leave_menu  = in_menu && (keys.run || menu_timeout);
  localparam logic [lcsc_pkg::MENU_VIEW_W-1:0] VIEW_LAST_W = lcsc_pkg::VIEW_LAST;
  wire view_up     = in_menu && keys.up && (view_reg != VIEW_LAST_W);
  wire view_down   = in_menu && keys.down && (view_reg != '0);

  always_comb begin
    mode_next = mode_reg;
    view_next = view_reg;
    case (mode_reg)
      LCSC_DISPLAY: begin
        if (any_key) begin
          mode_next = LCSC_MENU;
        end
      end
      LCSC_MENU: begin
        if (leave_menu) begin
          mode_next = LCSC_DISPLAY;
        end else if (keys.back) begin
          view_next = lcsc_pkg::VIEW_RESET;
        end else if (view_up) begin
          view_next = view_reg + lcsc_pkg::MENU_VIEW_W'(1);
        end else if (view_down) begin
          view_next = view_reg - lcsc_pkg::MENU_VIEW_W'(1);
        end
        // language view is forced until a language is confirmed
        if (lang_req_reg) begin
          view_next = lcsc_pkg::VIEW_LANGUAGE;
        end
      end
      default: begin
        mode_next = LCSC_DISPLAY;
      end
    endcase
  end

  wire lang_confirm = in_menu && keys.enter && (view_reg == lcsc_pkg::VIEW_LANGUAGE);

  always_ff @(posedge clk) begin
    if (reset) begin
      mode_reg     <= LCSC_DISPLAY;
      view_reg     <= lcsc_pkg::VIEW_RESET;
      cfg_reg      <= lcsc_pkg::CFG_DEFAULT;
      lang_req_reg <= 1'b1;
    end else begin
      mode_reg <= mode_next;
      view_reg <= view_next;
      if (factory_reset) begin
        cfg_reg <= lcsc_pkg::CFG_DEFAULT;
      end else if (leave_menu) begin
        cfg_reg <= edit_cfg;
      end
      // a default reset wins over a confirm in the same cycle
      if (factory_reset) begin
        lang_req_reg <= 1'b1;
      end else if (lang_confirm) begin
        lang_req_reg <= 1'b0;
      end
    end
  end

  // beam evaluation on the active configuration
  logic sync_lost;
  logic count_match;
  lcsc_beam_eval #(.BEAMS(BEAMS)) u_eval (
    .beam_blocked  (beam_blocked),
    .tol           (cfg_reg.tol),
    .taught_count  (cfg_reg.taught_count),
    .sync_lost     (sync_lost),
    .count_match   (count_match),
    .blocked_count ()
  );

  // setup procedure
  logic setup_run_reg;
  logic setup_msg_reg;
  wire pin_is_setup = (cfg_reg.pin_func == lcsc_pkg::LCSC_PIN_SETUP);
  wire pin_is_teach = (cfg_reg.pin_func == lcsc_pkg::LCSC_PIN_TEACH);
  wire key_setup    = in_menu && keys.teach && (view_reg == lcsc_pkg::VIEW_SETUP);
  wire setup_start  = !setup_run_reg && (key_setup || (pin_is_setup && pin_rise));

  always_ff @(posedge clk) begin
    if (reset) begin
      setup_run_reg <= 1'b0;
      setup_msg_reg <= 1'b0;
    end else if (setup_start) begin
      setup_run_reg <= 1'b1;
      setup_msg_reg <= 1'b0;
    end else if (setup_run_reg && (setup_ok || setup_fail)) begin
      setup_run_reg <= 1'b0;
      setup_msg_reg <= setup_ok && !setup_fail;
    end else if (any_key) begin
      setup_msg_reg <= 1'b0;
    end
  end

  // test sequence: hold high, release, then step beams off
  lcsc_test_e test_reg;
  logic [lcsc_pkg::BEAM_IDX_W-1:0] step_idx_reg;
  logic hold_done;
  logic step_tick;

  lcsc_tick_timer #(.LIMIT(TEST_CYC)) u_test_timer (
    .clk     (clk),
    .reset   (reset),
    .run     (test_high),
    .restart (1'b0),
    .done    (hold_done)
  );

  // step pace is a one-cycle enable from the divider
  lcsc_tick_timer #(.LIMIT(STEP_CYCLES)) u_step_timer (
    .clk     (clk),
    .reset   (reset),
    .run     (test_reg == LCSC_T_STEP),
    .restart (step_tick),
    .done    (step_tick)
  );

  always_ff @(posedge clk) begin
    if (reset) begin
      test_reg     <= LCSC_T_IDLE;
      step_idx_reg <= '0;
    end else begin
      case (test_reg)
        LCSC_T_IDLE: begin
          if (hold_done) begin
            test_reg <= LCSC_T_HOLD;
          end
        end
        LCSC_T_HOLD: begin
          if (!test_high) begin
            test_reg     <= LCSC_T_STEP;
            step_idx_reg <= '0;
          end
        end
        LCSC_T_STEP: begin
          if (step_tick) begin
            if (step_idx_reg == lcsc_pkg::BEAM_IDX_W'(BEAMS - 1)) begin
              test_reg <= LCSC_T_IDLE;
            end else begin
              step_idx_reg <= step_idx_reg + lcsc_pkg::BEAM_IDX_W'(1);
            end
          end
        end
        default: begin
          test_reg <= LCSC_T_IDLE;
        end
      endcase
    end
  end

  // switching output with sync-loss policy
  logic switch_next;
  always_comb begin
    switch_next = count_match;
    if (sync_lost) begin
      case (cfg_reg.nosync)
        lcsc_pkg::LCSC_NOSYNC_HOLD: switch_next = primary_switch_output;
        lcsc_pkg::LCSC_NOSYNC_ON:   switch_next = 1'b1;
        default:                    switch_next = 1'b0;
      endcase
    end
  end

  wire pin_drives = (cfg_reg.pin_func == lcsc_pkg::LCSC_PIN_SWITCH) ||
                    (cfg_reg.pin_func == lcsc_pkg::LCSC_PIN_ERROR);
  wire pin_value  = (cfg_reg.pin_func == lcsc_pkg::LCSC_PIN_ERROR) ? sync_lost : switch_next;

  always_ff @(posedge clk) begin
    if (reset) begin
      menu_active              <= 1'b0;
      menu_view                <= lcsc_pkg::VIEW_RESET;
      active_cfg               <= lcsc_pkg::CFG_DEFAULT;
      language_required        <= 1'b1;
      setup_running            <= 1'b0;
      setup_success_msg        <= 1'b0;
      show_all_free            <= 1'b0;
      error_msg                <= 1'b0;
      error_output             <= 1'b0;
      primary_switch_output    <= 1'b0;
      multipurpose_io_pin_out  <= 1'b0;
      multipurpose_io_pin_oe_n <= 1'b1;
      teach_request            <= 1'b0;
      emitter_beam_off         <= '0;
    end else begin
      menu_active              <= in_menu;
      menu_view                <= view_reg;
      active_cfg               <= cfg_reg;
      language_required        <= lang_req_reg;
      setup_running            <= setup_run_reg;
      setup_success_msg        <= setup_msg_reg;
      show_all_free            <= setup_msg_reg;
      error_msg                <= sync_lost;
      error_output             <= sync_lost;
      primary_switch_output    <= switch_next;
      multipurpose_io_pin_out  <= pin_value;
      multipurpose_io_pin_oe_n <= !pin_drives;
      teach_request            <= pin_is_teach && pin_rise;
      emitter_beam_off         <= (test_reg == LCSC_T_STEP) ?
                                  (BEAMS'(1) << step_idx_reg) : '0;
    end
  end
endmodule : lcsc_control
`default_nettype wire

// *** dv/lcsc_chk.sv ***
`timescale 1ns/1ps
`default_nettype none
module lcsc_chk #(
  parameter int unsigned BEAMS    = 16,
  parameter int unsigned MENU_CYC = 20
) (
  input wire logic                 clk,
  input wire logic                 reset,
  input wire lcsc_pkg::lcsc_keys_s keys,
  input wire logic                 setting_adjust,
  input wire logic [BEAMS-1:0]     beam_blocked,
  input wire logic                 menu_active,
  input wire logic [3:0]           menu_view,
  input wire lcsc_pkg::lcsc_cfg_s  active_cfg,
  input wire logic                 language_required,
  input wire logic                 setup_running,
  input wire logic                 setup_success_msg,
  input wire logic                 show_all_free,
  input wire logic                 error_msg,
  input wire logic                 error_output,
  input wire logic                 primary_switch_output,
  input wire logic                 multipurpose_io_pin_oe_n,
  input wire logic                 teach_request,
  input wire logic [BEAMS-1:0]     emitter_beam_off
);
  default clocking @(posedge clk); endclocking
  default disable iff (reset);
  logic       sync_gone;
  logic [7:0] idle_cnt;
  assign sync_gone = beam_blocked[0] & beam_blocked[BEAMS-1];
  // any operator action restarts the idle count
  always_ff @(posedge clk) begin
    idle_cnt <= (reset || !menu_active || |keys || setting_adjust) ? 8'h00 : idle_cnt + 8'h01;
  end
  sequence s_key_idle;
    (keys != '0) && !menu_active;
  endsequence
  sequence s_err_held;
    error_output [*3];
  endsequence
  menu_open_a: assert property (s_key_idle |-> ##2 menu_active) else $error("menu not opened");
  menu_timeout_a: assert property (idle_cnt <= MENU_CYC + 4) else $error("menu idle too long");
  cfg_defer_a: assert property (menu_active && $past(menu_active) |-> $stable(active_cfg))
    else $error("config changed in menu");
  view_bound_a: assert property (menu_view <= lcsc_pkg::VIEW_LAST) else $error("view out of range");
  lang_view_a: assert property (language_required && menu_active && $past(menu_active)
    |-> menu_view == lcsc_pkg::VIEW_LANGUAGE) else $error("language view skipped");
  setup_msg_a: assert property ($rose(setup_success_msg) |-> $past(setup_running) && show_all_free)
    else $error("success message without setup");
  beam_step_a: assert property (emitter_beam_off != '0 && $past(emitter_beam_off) != '0
    && $changed(emitter_beam_off) |-> emitter_beam_off == ($past(emitter_beam_off) << 1))
    else $error("beam order wrong");
  beam_onehot_a: assert property ($onehot0(emitter_beam_off)) else $error("several beams off");
  sync_err_a: assert property (error_output == $past(sync_gone) && error_msg == error_output)
    else $error("error output wrong");
  nosync_pol_a: assert property (s_err_held |-> active_cfg != $past(active_cfg, 2)
    || active_cfg.nosync == lcsc_pkg::LCSC_NOSYNC_HOLD
    || primary_switch_output == (active_cfg.nosync == lcsc_pkg::LCSC_NOSYNC_ON))
    else $error("sync loss policy broken");
  pin_dir_a: assert property (!$past(reset, 2) && active_cfg == $past(active_cfg, 2)
    |-> multipurpose_io_pin_oe_n == (active_cfg.pin_func inside {lcsc_pkg::LCSC_PIN_SETUP,
    lcsc_pkg::LCSC_PIN_TEACH})) else $error("pin direction wrong");
  teach_pin_a: assert property (teach_request |-> active_cfg.pin_func == lcsc_pkg::LCSC_PIN_TEACH)
    else $error("teach without teach pin");
endmodule : lcsc_chk
`default_nettype wire

// *** dv/lcsc_partner.sv ***
`timescale 1ns/1ps
`default_nettype none
// machine controller: shares the multipurpose wire and counts sync error events
module lcsc_partner (
  input wire logic  clk,
  input wire logic  reset,
  input wire logic  error_output,
  input wire logic  pin_out,
  input wire logic  pin_oe_n,
  input wire logic  ctrl_level,
  output logic      pin_level,
  output var int    err_events
);
  logic err_q;
  // the device wins the wire whenever it drives it
  assign pin_level = !pin_oe_n ? pin_out : ctrl_level;
  always @(posedge clk) begin
    err_q <= error_output;
    if (reset) err_events <= 0;
    else if (error_output && !err_q) err_events <= err_events + 1;
  end
endmodule : lcsc_partner
`default_nettype wire

// *** dv/light_curtain_startup_sync_control_bench.sv ***
`timescale 1ns/1ps
`default_nettype none
module light_curtain_startup_sync_control_bench;
  localparam int unsigned BEAMS    = 16;
  localparam int unsigned MENU_CYC = 20;
  logic clk, reset, setting_adjust, factory_reset, test_input, ctrl_level, setup_ok, setup_fail;
  lcsc_pkg::lcsc_keys_s keys;
  lcsc_pkg::lcsc_cfg_s  edit_cfg, active_cfg;
  logic [BEAMS-1:0]     beam_blocked, emitter_beam_off;
  logic [3:0]           menu_view;
  logic menu_active, language_required, setup_running, setup_success_msg, show_all_free;
  logic error_msg, error_output, primary_switch_output, multipurpose_io_pin_out;
  logic multipurpose_io_pin_oe_n, teach_request;
  wire logic            multipurpose_io_pin_in;
  int                   err_events, miscompares, checks, cycles;

  lcsc_control #(.BEAMS(BEAMS), .MENU_CYC(MENU_CYC), .TEST_CYC(10), .STEP_CYCLES(3)) dut_u (
    .clk(clk), .reset(reset), .keys(keys), .setting_adjust(setting_adjust),
    .edit_cfg(edit_cfg), .factory_reset(factory_reset), .beam_blocked(beam_blocked),
    .test_input(test_input), .multipurpose_io_pin_in(multipurpose_io_pin_in),
    .setup_ok(setup_ok), .setup_fail(setup_fail), .menu_active(menu_active),
    .menu_view(menu_view), .active_cfg(active_cfg), .language_required(language_required),
    .setup_running(setup_running), .setup_success_msg(setup_success_msg),
    .show_all_free(show_all_free), .error_msg(error_msg), .error_output(error_output),
    .primary_switch_output(primary_switch_output),
    .multipurpose_io_pin_out(multipurpose_io_pin_out),
    .multipurpose_io_pin_oe_n(multipurpose_io_pin_oe_n), .teach_request(teach_request),
    .emitter_beam_off(emitter_beam_off));
  lcsc_partner partner_u (.clk(clk), .reset(reset), .error_output(error_output),
    .pin_out(multipurpose_io_pin_out), .pin_oe_n(multipurpose_io_pin_oe_n),
    .ctrl_level(ctrl_level), .pin_level(multipurpose_io_pin_in), .err_events(err_events));

  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end
  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (cycles == 6000) begin
      miscompares++;
      complete_run();
    end
  end

  task automatic complete_run;
    $display("checks %0d miscompares %0d", checks, miscompares);
    if (miscompares == 0 && checks > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask : complete_run
  task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp) begin
      miscompares++;
      $display("[ERR] %s expected %h seen %h", name, exp, seen);
    end
  endtask : chk
  task automatic idle(input int n);
    repeat (n) @(negedge clk);
  endtask : idle
  // key bits: up 20, down 10, back 08, run 04, enter 02, teach 01
  task automatic press(input logic [5:0] k);
    @(negedge clk) keys = k;
    @(negedge clk) keys = '0;
  endtask : press
  function automatic lcsc_pkg::lcsc_cfg_s mk(input logic [1:0] p, n, t, input logic [4:0] c);
    mk = {p, n, t, c};
  endfunction : mk
  task automatic apply(input lcsc_pkg::lcsc_cfg_s c);
    edit_cfg = c;
    press(6'h08);
    idle(3);
    press(6'h04);
    idle(3);
  endtask : apply

  task automatic t_menu;
    chk("cfg_rst", active_cfg, lcsc_pkg::CFG_DEFAULT);
    chk("lang_rst", language_required, 1'b1);
    press(6'h20); idle(2);
    chk("menu", menu_active, 1'b1);
    chk("view", menu_view, lcsc_pkg::VIEW_LANGUAGE);
    press(6'h20); idle(2);
    chk("view", menu_view, lcsc_pkg::VIEW_LANGUAGE);
    press(6'h02); idle(2);
    chk("lang", language_required, 1'b0);
    press(6'h20); idle(2);
    chk("view", menu_view, 4'hB);
    press(6'h10); idle(2);
    chk("view", menu_view, 4'hA);
    press(6'h08); idle(2);
    chk("view", menu_view, 4'h0);
    edit_cfg = mk(2'h0, 2'h2, 2'h3, 5'h03);
    press(6'h20); press(6'h20); idle(2);
    chk("cfg", active_cfg, lcsc_pkg::CFG_DEFAULT);
    press(6'h04); idle(3);
    chk("menu", menu_active, 1'b0);
    chk("cfg", active_cfg, mk(2'h0, 2'h2, 2'h3, 5'h03));
    press(6'h02); idle(2);
    chk("view", menu_view, 4'h2);
    repeat (12) press(6'h20);
    idle(2);
    chk("view", menu_view, lcsc_pkg::VIEW_SETUP);
    press(6'h01); idle(3);
    chk("setup", setup_running, 1'b1);
    @(negedge clk) setup_fail = 1'b1;
    @(negedge clk) setup_fail = 1'b0;
    idle(2);
    chk("setup", setup_running, 1'b0);
    chk("msg", setup_success_msg, 1'b0);
    press(6'h04); idle(3);
    $display("t_menu done");
  endtask : t_menu
  task automatic t_timeout;
    press(6'h08); idle(10);
    @(negedge clk) setting_adjust = 1'b1;
    @(negedge clk) setting_adjust = 1'b0;
    idle(16);
    chk("menu", menu_active, 1'b1);
    idle(10);
    chk("menu", menu_active, 1'b0);
    $display("t_timeout done");
  endtask : t_timeout
  task automatic t_pin;
    logic seen;
    seen = 1'b0;
    apply(mk(2'h2, 2'h0, 2'h0, 5'h00));
    chk("oe_n", multipurpose_io_pin_oe_n, 1'b1);
    beam_blocked = '0;
    @(negedge clk) ctrl_level = 1'b1;
    idle(8);
    ctrl_level = 1'b0;
    chk("setup", setup_running, 1'b1);
    @(negedge clk) setup_ok = 1'b1;
    @(negedge clk) setup_ok = 1'b0;
    idle(2);
    chk("msg", setup_success_msg, 1'b1);
    chk("free", show_all_free, 1'b1);
    apply(mk(2'h3, 2'h0, 2'h0, 5'h00));
    ctrl_level = 1'b1;
    repeat (8) @(negedge clk) seen |= teach_request;
    ctrl_level = 1'b0;
    chk("teach", seen, 1'b1);
    chk("setup", setup_running, 1'b0);
    apply(mk(2'h1, 2'h0, 2'h0, 5'h00));
    chk("oe_n", multipurpose_io_pin_oe_n, 1'b0);
    $display("t_pin done");
  endtask : t_pin
  task automatic t_sync;
    // hold policy keeps the pre-loss level although two blocked beams now match
    apply(mk(2'h0, 2'h0, 2'h0, 5'h02));
    beam_blocked = 16'h0001; idle(3);
    chk("err", error_output, 1'b0);
    beam_blocked = 16'h8001; idle(3);
    chk("err", error_output, 1'b1);
    chk("err_msg", error_msg, 1'b1);
    chk("sw", primary_switch_output, 1'b0);
    chk("events", err_events, 1);
    apply(mk(2'h0, 2'h2, 2'h0, 5'h1F));
    chk("sw", primary_switch_output, 1'b1);
    chk("pin_out", multipurpose_io_pin_out, 1'b1);
    apply(mk(2'h0, 2'h1, 2'h0, 5'h02));
    chk("sw", primary_switch_output, 1'b0);
    beam_blocked = '0; idle(3);
    chk("err", error_output, 1'b0);
    $display("t_sync done");
  endtask : t_sync
  task automatic t_tol;
    logic e;
    for (int t = 0; t < 4; t++) begin
      apply(mk(2'h0, 2'h0, 2'(t), 5'h03));
      for (int k = 2; k < 5; k++) begin
        // minus tolerance is bit 0 of the code, plus is bit 1
        e = (k == 3) || (k == 2 && t[0]) || (k == 4 && t[1]);
        beam_blocked = BEAMS'(((1 << k) - 1) << 1); idle(4);
        chk("sw_tol", primary_switch_output, e);
      end
    end
    beam_blocked = '0;
    $display("t_tol done");
  endtask : t_tol
  task automatic t_test;
    int n;
    @(negedge clk) test_input = 1'b1;
    idle(4); test_input = 1'b0; idle(30);
    chk("beam_off", emitter_beam_off, '0);
    test_input = 1'b1; idle(14);
    chk("beam_off", emitter_beam_off, '0);
    test_input = 1'b0;
    for (int i = 0; i < BEAMS; i++) begin
      n = 0;
      while (emitter_beam_off !== (BEAMS'(1) << i) && n < 20) begin
        @(negedge clk);
        n++;
      end
      chk("beam_off", emitter_beam_off, BEAMS'(1) << i);
    end
    idle(8);
    chk("beam_off", emitter_beam_off, '0);
    $display("t_test done");
  endtask : t_test
  task automatic t_factory;
    @(negedge clk) factory_reset = 1'b1;
    @(negedge clk) factory_reset = 1'b0;
    idle(3);
    chk("lang", language_required, 1'b1);
    chk("cfg", active_cfg, lcsc_pkg::CFG_DEFAULT);
    $display("t_factory done");
  endtask : t_factory

  initial begin
    {setting_adjust, factory_reset, test_input, ctrl_level, setup_ok, setup_fail} = '0;
    keys = '0;
    edit_cfg = lcsc_pkg::CFG_DEFAULT;
    beam_blocked = '0;
    {miscompares, checks, cycles} = '0;
    reset = 1'b1;
    repeat (16) @(posedge clk);
    @(negedge clk) reset = 1'b0;
    t_menu();
    t_timeout();
    t_pin();
    t_sync();
    t_tol();
    t_test();
    t_factory();
    complete_run();
  end
endmodule : light_curtain_startup_sync_control_bench

bind lcsc_control lcsc_chk #(.BEAMS(BEAMS), .MENU_CYC(MENU_CYC)) chk_u (
  .clk(clk), .reset(reset), .keys(keys), .setting_adjust(setting_adjust),
  .beam_blocked(beam_blocked), .menu_active(menu_active), .menu_view(menu_view),
  .active_cfg(active_cfg), .language_required(language_required),
  .setup_running(setup_running), .setup_success_msg(setup_success_msg),
  .show_all_free(show_all_free), .error_msg(error_msg), .error_output(error_output),
  .primary_switch_output(primary_switch_output),
  .multipurpose_io_pin_oe_n(multipurpose_io_pin_oe_n), .teach_request(teach_request),
  .emitter_beam_off(emitter_beam_off));
`default_nettype wire
